//--- rtl/tip_pkg.sv
package tip_pkg;
  localparam int NPORT = 5;
  localparam int NPIN = 32;
  localparam int NCLK = 6;
  localparam int COUNT_W = 16;
  localparam int PW [NPORT] = '{1, 4, 8, 16, 32};
  localparam logic [31:0] PMASK [NPORT] = '{32'h0000_0001, 32'h0000_000f,
    32'h0000_00ff, 32'h0000_ffff, 32'hffff_ffff};
  localparam int LINK_LO = 2;
  localparam int LINK_W = 8;

  // per-port register offsets, port base = index * 0x20
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_COND = 5'h04;
  localparam logic [4:0] OFF_TIME = 5'h08;
  localparam logic [4:0] OFF_COUNT = 5'h0c;
  localparam logic [4:0] OFF_TSTAMP = 5'h10;
  localparam logic [4:0] OFF_DATA = 5'h14;
  localparam logic [4:0] OFF_STATUS = 5'h18;
  localparam logic [11:0] PORT_STRIDE = 12'h020;
  // global page at 0x100: word 0 link enable, words 1..5 clock blocks
  localparam logic [6:0] GLOB_PAGE = 7'h08;
  localparam logic [2:0] GLOB_LINK = 3'h0;
  localparam logic [2:0] GLOB_LAST = 3'h5;

  localparam logic [1:0] COND_NONE = 2'h0;
  localparam logic [1:0] COND_EQ = 2'h1;
  localparam logic [1:0] COND_NEQ = 2'h2;
  localparam logic [2:0] CLK_REF = 3'h0;

  typedef struct packed {
    logic [2:0] clksel;
    logic [2:0] rsvd;
    logic [1:0] cond;
    logic strobe;
    logic dir_out;
    logic en;
  } tip_ctrl_s;
  localparam tip_ctrl_s CTRL_RESET = '{clksel: CLK_REF, cond: COND_NONE,
    default: 1'b0};

  typedef struct packed {
    logic ext;
    logic [7:0] div;
  } tip_clkdiv_s;
  localparam tip_clkdiv_s CLKDIV_RESET = '0;

  typedef struct packed {
    logic wr;
    logic [11:0] addr;
    logic [31:0] wdata;
  } tip_apb_req_s;
endpackage : tip_pkg

//--- rtl/tip_top.sv
`timescale 1ns/1ns
`default_nettype none
module tip_top
  import tip_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic [NPIN-1:0] i_pin_in,
  output logic [NPIN-1:0] o_pin_out,
  output logic [NPIN-1:0] o_pin_oe_n,
  input wire logic [NPORT-1:0] i_strobe_in,
  output logic [NPORT-1:0] o_strobe_out,
  input wire logic [LINK_W-1:0] i_link_dout,
  input wire logic [LINK_W-1:0] i_link_drive,
  output logic [LINK_W-1:0] o_link_din,
  output logic [NPORT-1:0] o_event
);

  function automatic logic hit(input logic [11:0] a, input int p,
                               input logic [4:0] off);
    hit = (a == (12'(p) * PORT_STRIDE + {7'h00, off}));
  endfunction : hit

  // pin and strobe synchronisers
  logic [NPIN-1:0] pin_s1;
  logic [NPIN-1:0] pin_s2;
  logic [NPORT-1:0] stb_s1;
  logic [NPORT-1:0] stb_s2;
  logic ext_prev;

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      stb_s1 <= '0;
      stb_s2 <= '0;
      ext_prev <= 1'b0;
    end else begin
      pin_s1 <= i_pin_in;
      pin_s2 <= pin_s1;
      stb_s1 <= i_strobe_in;
      stb_s2 <= stb_s1;
      ext_prev <= pin_s2[0];
    end
  end

  // bus decode
  tip_apb_req_s req;
  wire setup = i_psel & ~i_penable;
  wire acc = i_psel & i_penable & o_pready & ~o_pslverr;
  assign req = '{wr: i_pwrite, addr: i_paddr, wdata: i_pwdata};
  wire [2:0] port_idx = req.addr[7:5];
  wire [4:0] reg_off = req.addr[4:0];
  wire [2:0] glob_idx = req.addr[4:2];
  wire off_ok = (reg_off[1:0] == 2'b00) && (reg_off <= OFF_STATUS);
  wire in_port = (req.addr[11:8] == 4'h0) && (port_idx < 3'(NPORT)) &&
                 off_ok;
  wire in_glob = (req.addr[11:5] == GLOB_PAGE) &&
                 (req.addr[1:0] == 2'b00) && (glob_idx <= GLOB_LAST);
  wire wr = acc & req.wr;
  wire rd = acc & ~req.wr;

  // global state
  logic link_en;
  tip_clkdiv_s clkdiv [NCLK];
  logic [7:0] div_cnt [NCLK];
  logic [NCLK-1:0] tick;

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      link_en <= 1'b0;
    end else if (wr && in_glob && glob_idx == GLOB_LINK) begin
      link_en <= req.wdata[0];
    end
  end

  // block zero ticks every core cycle: the reference
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      tick[0] <= 1'b0;
    end else begin
      tick[0] <= 1'b1;
    end
  end
  assign clkdiv[0] = CLKDIV_RESET;
  assign div_cnt[0] = '0;

  for (genvar b = 1; b < NCLK; b++) begin : g_clk
    always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
        clkdiv[b] <= CLKDIV_RESET;
        div_cnt[b] <= '0;
        tick[b] <= 1'b0;
      end else begin
        if (wr && in_glob && glob_idx == 3'(b)) begin
          clkdiv[b] <= req.wdata[8:0];
        end
        if (clkdiv[b].ext) begin
          tick[b] <= pin_s2[0] & ~ext_prev;
          div_cnt[b] <= '0;
        end else if (div_cnt[b] >= clkdiv[b].div) begin
          tick[b] <= 1'b1;
          div_cnt[b] <= '0;
        end else begin
          tick[b] <= 1'b0;
          div_cnt[b] <= div_cnt[b] + 8'h01;
        end
      end
    end
  end

  // per-port state
  tip_ctrl_s ctrl [NPORT];
  logic [31:0] cond_val [NPORT];
  logic [COUNT_W-1:0] time_val [NPORT];
  logic [NPORT-1:0] time_arm;
  logic [COUNT_W-1:0] count [NPORT];
  logic [COUNT_W-1:0] tstamp [NPORT];
  logic [31:0] shreg [NPORT];
  logic [5:0] sh_cnt [NPORT];
  logic [31:0] xfer [NPORT];
  logic [NPORT-1:0] xfer_v;
  logic [31:0] out_val [NPORT];
  logic [31:0] port_rd [NPORT];
  logic [NPORT-1:0] refuse;

  for (genvar g = 0; g < NPORT; g++) begin : g_port
    localparam int W = PW[g];
    localparam logic [5:0] SLOTS = 6'(32 / W);
    wire sel = (port_idx == 3'(g)) && in_port;
    wire tick_p = (ctrl[g].clksel < 3'(NCLK)) ? tick[ctrl[g].clksel] :
                  1'b0;
    wire [31:0] pval = pin_s2 & PMASK[g];
    wire cond_ok = (ctrl[g].cond == COND_NONE) ||
                   (ctrl[g].cond == COND_EQ && pval == cond_val[g]) ||
                   (ctrl[g].cond == COND_NEQ && pval != cond_val[g]);
    wire time_ok = ~time_arm[g] | (count[g] == time_val[g]);
    wire stb_ok = ~ctrl[g].strobe | stb_s2[g];
    wire sh_full = (sh_cnt[g] == SLOTS);
    wire go_in = ctrl[g].en & ~ctrl[g].dir_out & tick_p & cond_ok &
                 time_ok & stb_ok & ~sh_full;
    wire go_out = ctrl[g].en & ctrl[g].dir_out & tick_p & time_ok &
                  (sh_cnt[g] != 6'h00);
    wire move_in = ~ctrl[g].dir_out & sh_full & ~xfer_v[g];
    wire load_out = ctrl[g].dir_out & (sh_cnt[g] == 6'h00) & xfer_v[g];
    wire pop = rd & sel & (reg_off == OFF_DATA) & ~ctrl[g].dir_out;
    wire push = wr & sel & (reg_off == OFF_DATA);
    wire [31:0] status = {28'h000_0000, ctrl[g].cond != COND_NONE,
                          time_arm[g], sh_full, xfer_v[g]};

    assign refuse[g] = sel && (reg_off == OFF_DATA) && req.wr &&
                       (xfer_v[g] || !ctrl[g].dir_out);

    assign port_rd[g] =
      (reg_off == OFF_CTRL) ? 32'(ctrl[g]) :
      (reg_off == OFF_COND) ? cond_val[g] :
      (reg_off == OFF_TIME) ? {16'h0000, time_val[g]} :
      (reg_off == OFF_COUNT) ? {16'h0000, count[g]} :
      (reg_off == OFF_TSTAMP) ? {16'h0000, tstamp[g]} :
      (reg_off == OFF_DATA) ? xfer[g] : status;

    always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
        ctrl[g] <= CTRL_RESET;
        cond_val[g] <= '0;
        time_val[g] <= '0;
        time_arm[g] <= 1'b0;
        count[g] <= '0;
        tstamp[g] <= '0;
        shreg[g] <= '0;
        sh_cnt[g] <= '0;
        xfer[g] <= '0;
        xfer_v[g] <= 1'b0;
        out_val[g] <= '0;
        o_strobe_out[g] <= 1'b0;
        o_event[g] <= 1'b0;
      end else begin
        o_strobe_out[g] <= 1'b0;
        o_event[g] <= 1'b0;
        if (tick_p) begin
          count[g] <= count[g] + 16'h0001;
        end
        if (go_in) begin
          // lsb-first serialisation, W bits per tick
          shreg[g] <= (shreg[g] >> W) | (pval << (32 - W));
          sh_cnt[g] <= sh_cnt[g] + 6'h01;
          time_arm[g] <= 1'b0;
          ctrl[g].cond <= COND_NONE;
        end
        if (move_in) begin
          xfer[g] <= shreg[g];
          sh_cnt[g] <= '0;
          tstamp[g] <= count[g];
          o_event[g] <= 1'b1;
        end
        if (load_out) begin
          shreg[g] <= xfer[g];
          sh_cnt[g] <= SLOTS;
          o_event[g] <= 1'b1;
        end
        if (go_out) begin
          out_val[g] <= shreg[g] & PMASK[g];
          shreg[g] <= shreg[g] >> W;
          sh_cnt[g] <= sh_cnt[g] - 6'h01;
          tstamp[g] <= count[g];
          time_arm[g] <= 1'b0;
          o_strobe_out[g] <= ctrl[g].strobe;
        end
        // set wins over clear
        if (move_in || push) begin
          xfer_v[g] <= 1'b1;
        end else if (pop || load_out) begin
          xfer_v[g] <= 1'b0;
        end
        if (push) begin
          xfer[g] <= req.wdata;
        end
        if (wr && sel) begin
          unique case (reg_off)
            OFF_CTRL: begin
              ctrl[g] <= req.wdata[10:0];
              ctrl[g].rsvd <= '0;
            end
            OFF_COND: begin
              cond_val[g] <= req.wdata & PMASK[g];
            end
            OFF_TIME: begin
              time_val[g] <= req.wdata[15:0];
              time_arm[g] <= 1'b1;
            end
            default: begin
            end
          endcase
        end
      end
    end
  end

  // pin ownership: wider first, narrower overwrites, link last
  logic [NPIN-1:0] next_pin_out;
  logic [NPIN-1:0] next_pin_oe_n;

  always_comb begin
    next_pin_out = '0;
    next_pin_oe_n = '1;
    for (int p = 0; p < NPIN; p++) begin
      for (int k = NPORT - 1; k >= 0; k--) begin
        if (ctrl[k].en && p < PW[k]) begin
          next_pin_oe_n[p] = ~ctrl[k].dir_out;
          next_pin_out[p] = out_val[k][p];
        end
      end
      if (link_en && p >= LINK_LO && p < LINK_LO + LINK_W) begin
        next_pin_oe_n[p] = ~i_link_drive[p - LINK_LO];
        next_pin_out[p] = i_link_dout[p - LINK_LO];
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_pin_out <= '0;
      o_pin_oe_n <= '1;
      o_link_din <= '0;
    end else begin
      o_pin_out <= next_pin_out;
      o_pin_oe_n <= next_pin_oe_n;
      o_link_din <= pin_s2[LINK_LO +: LINK_W];
    end
  end

  // read data and answer prepared in the setup cycle
  logic [31:0] glob_rd;
  logic [31:0] next_rdata;
  logic next_err;

  assign glob_rd = (glob_idx == GLOB_LINK) ? {31'h0000_0000, link_en} :
                   {23'h00_0000, clkdiv[glob_idx]};
  assign next_rdata = in_port ? port_rd[port_idx] :
                      in_glob ? glob_rd : 32'h0000_0000;
  assign next_err = ~(in_port | in_glob) |
                    (in_port & refuse[port_idx]);

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= '0;
    end else begin
      o_pready <= setup;
      o_pslverr <= setup & next_err;
      if (setup) begin
        o_prdata <= req.wr ? 32'h0000_0000 : next_rdata;
      end
    end
  end

  logic unused;
  assign unused = ^{hit(12'h000, 0, OFF_CTRL)};

endmodule : tip_top
`default_nettype wire

//--- verification/tip_top_sva.sv
`timescale 1ns/1ns
`default_nettype none
module tip_chk
  import tip_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic [NPIN-1:0] i_pin_in,
  input wire logic [NPIN-1:0] o_pin_oe_n,
  input wire logic [LINK_W-1:0] i_link_drive,
  input wire logic [LINK_W-1:0] o_link_din,
  input wire logic [NPORT-1:0] o_event
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);
  logic link_en;
  wire logic stp;
  wire logic wr_ok;
  assign stp = i_psel && !i_penable;
  assign wr_ok = i_psel && i_penable && o_pready && !o_pslverr && i_pwrite;
  // shadow of the link enable bit
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      link_en <= 1'b0;
    end else if (wr_ok && i_paddr == 12'h100) begin
      link_en <= i_pwdata[0];
    end
  end
  AST_READY_ONE: assert property (stp |=> o_pready)
    else $error("no ready after setup");
  AST_READY_ONLY: assert property (!stp |=> !o_pready)
    else $error("ready without setup");
  AST_ERR_PAIR: assert property (o_pslverr |-> o_pready)
    else $error("error outside access");
  AST_ERR_ZERO: assert property (
    o_pslverr && !i_pwrite |-> o_prdata == 32'h0000_0000)
    else $error("refused read not zero");
  AST_RD_HOLD: assert property (
    $past(i_rst_n) && !$past(stp) |-> $stable(o_prdata))
    else $error("read data moved");
  AST_RESET_OFF: assert property (
    $rose(i_rst_n) |-> &o_pin_oe_n && o_event == '0)
    else $error("pins driven after reset");
  AST_LINK_PINS: assert property (
    link_en && $past(link_en, 2) && i_link_drive == '0 |-> &o_pin_oe_n[9:2])
    else $error("port drives link pins");
  AST_SYNC_PINS: assert property (
    ($stable(i_pin_in[9:2]))[*4] ##0 $past(i_rst_n, 5)
    |-> o_link_din == i_pin_in[9:2])
    else $error("link pin sync wrong");
  cover property (o_pslverr);
  cover property (o_event != '0);
  cover property (link_en && &o_pin_oe_n[9:2]);
endmodule : tip_chk
bind tip_top tip_chk tip_chk_i (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
  .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
  .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .i_pin_in(i_pin_in),
  .o_pin_oe_n(o_pin_oe_n), .i_link_drive(i_link_drive),
  .o_link_din(o_link_din), .o_event(o_event));
`default_nettype wire

//--- verification/tip_pins_model.sv
`timescale 1ns/1ns
`default_nettype none
module tip_pins_model
  import tip_pkg::*;
(
  input wire logic [NPIN-1:0] i_level,
  input wire logic [NPIN-1:0] i_pin_out,
  input wire logic [NPIN-1:0] i_pin_oe_n,
  input wire logic [NPORT-1:0] i_strobe,
  output logic [NPIN-1:0] o_pin_in,
  output logic [NPORT-1:0] o_strobe_in
);
  // driven pins read back the port value, released ones the board level
  assign o_pin_in = (i_pin_out & ~i_pin_oe_n) | (i_level & i_pin_oe_n);
  // far-side strobe level, set by the bench
  assign o_strobe_in = i_strobe;
endmodule : tip_pins_model
`default_nettype wire

//--- verification/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb
  import tip_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] level = '0;
  logic [NPORT-1:0] stb_lvl = '0;
  logic [NPORT-1:0] stb_out;
  logic [15:0] ts;
  int n_stb = 0;
  logic [31:0] prdata, pin_in, pin_out, oe_n, rdat;
  logic [NPORT-1:0] strobe_in, ev;
  logic [LINK_W-1:0] link_din;
  logic pready, pslverr, rerr;
  int n_mismatch = 0;
  int checks = 0;
  int cyc = 0;
  int ev0 = 0;
  int e0;
  initial begin
    forever #4 clk = ~clk;
  end
  tip_top tip_top_i (.i_core_clk(clk), .i_rst_n(rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_pin_in(pin_in), .o_pin_out(pin_out),
    .o_pin_oe_n(oe_n), .i_strobe_in(strobe_in), .o_strobe_out(stb_out),
    .i_link_dout({LINK_W{1'b0}}), .i_link_drive({LINK_W{1'b0}}),
    .o_link_din(link_din), .o_event(ev));
  tip_pins_model tip_pins_model_i (.i_level(level), .i_pin_out(pin_out),
    .i_pin_oe_n(oe_n), .i_strobe(stb_lvl), .o_pin_in(pin_in),
    .o_strobe_in(strobe_in));
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (ev[0] === 1'b1) begin
      ev0 <= ev0 + 1;
    end
    if (stb_out[3] === 1'b1) begin
      n_stb <= n_stb + 1;
    end
    if (cyc == 3000) begin
      $display("[ERR] %0t timeout", $time);
      n_mismatch++;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : xfer
  // two counter reads twelve cycles apart
  task automatic cnt_gap(input logic [11:0] a, input logic [15:0] d);
    logic [15:0] c;
    xfer(1'b0, a, '0);
    c = rdat[15:0];
    repeat (9) @(posedge clk);
    xfer(1'b0, a, '0);
    chk({16'h0000, rdat[15:0] - c}, {16'h0000, d});
  endtask : cnt_gap
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    xfer(1'b0, 12'h000, '0);
    chk(rdat, 32'h0000_0000);
    xfer(1'b0, 12'h0a0, '0);
    chk({31'h0, rerr}, 32'h0000_0001);
    level <= 32'h0000_00a5;
    xfer(1'b1, 12'h040, 32'h0000_0005);
    repeat (12) @(posedge clk);
    xfer(1'b0, 12'h058, '0);
    chk(rdat & 32'h0000_0003, 32'h0000_0000);
    stb_lvl <= '1;
    repeat (12) @(posedge clk);
    xfer(1'b0, 12'h058, '0);
    chk(rdat & 32'h0000_0001, 32'h0000_0001);
    xfer(1'b0, 12'h054, '0);
    chk(rdat, 32'ha5a5_a5a5);
    xfer(1'b0, 12'h050, '0);
    ts = rdat[15:0];
    xfer(1'b0, 12'h04c, '0);
    chk({16'h0000, rdat[15:0] - ts}, 32'h0000_0004);
    cnt_gap(12'h04c, 16'h000c);
    xfer(1'b1, 12'h040, '0);
    level <= '0;
    xfer(1'b1, 12'h004, 32'h0000_0001);
    xfer(1'b1, 12'h000, 32'h0000_0009);
    repeat (6) @(posedge clk);
    e0 = ev0;
    xfer(1'b0, 12'h018, '0);
    chk(rdat & 32'h0000_0009, 32'h0000_0008);
    level <= 32'h0000_00a5;
    repeat (40) @(posedge clk);
    xfer(1'b0, 12'h018, '0);
    chk(rdat & 32'h0000_0008, '0);
    chk({31'h0, ev0 > e0}, 32'h0000_0001);
    xfer(1'b0, 12'h014, '0);
    chk(rdat, 32'hffff_ffff);
    // not-equal wait: pin 0 equals the compare value, so it holds
    xfer(1'b1, 12'h000, 32'h0000_0011);
    repeat (6) @(posedge clk);
    xfer(1'b0, 12'h018, '0);
    chk(rdat & 32'h0000_0008, 32'h0000_0008);
    level <= 32'h0000_00a4;
    repeat (6) @(posedge clk);
    xfer(1'b0, 12'h018, '0);
    chk(rdat & 32'h0000_0008, '0);
    xfer(1'b1, 12'h000, '0);
    // timed output with strobe, released 40 counts ahead
    xfer(1'b1, 12'h060, 32'h0000_0007);
    xfer(1'b0, 12'h06c, '0);
    ts = rdat[15:0];
    xfer(1'b1, 12'h068, {16'h0000, ts + 16'h0028});
    xfer(1'b1, 12'h074, 32'h1234_5678);
    chk({31'h0, rerr}, '0);
    xfer(1'b0, 12'h078, '0);
    chk(rdat & 32'h0000_0005, 32'h0000_0004);
    chk(n_stb, '0);
    repeat (40) @(posedge clk);
    chk(n_stb, 32'h0000_0002);
    xfer(1'b0, 12'h070, '0);
    chk({16'h0000, rdat[15:0]}, {16'h0000, ts + 16'h0029});
    chk(pin_out, 32'h0000_1234);
    xfer(1'b1, 12'h020, 32'h0000_0001);
    xfer(1'b1, 12'h034, 32'h0000_0001);
    chk({31'h0, rerr}, 32'h0000_0001);
    chk(oe_n, 32'hffff_000f);
    chk(pin_out & 32'h0000_fff0, 32'h0000_1230);
    xfer(1'b1, 12'h100, 32'h0000_0001);
    repeat (4) @(posedge clk);
    chk(oe_n, 32'hffff_03ff);
    chk({24'h0, link_din}, 32'h0000_0029);
    xfer(1'b1, 12'h104, 32'h0000_0003);
    xfer(1'b0, 12'h104, '0);
    chk(rdat, 32'h0000_0003);
    xfer(1'b1, 12'h080, 32'h0000_0101);
    cnt_gap(12'h08c, 16'h0003);
    // block 2 clocked from pin 0: three rising edges
    xfer(1'b1, 12'h108, 32'h0000_0100);
    xfer(1'b1, 12'h080, 32'h0000_0201);
    xfer(1'b0, 12'h08c, '0);
    ts = rdat[15:0];
    repeat (3) begin
      level[0] <= 1'b1;
      repeat (4) @(posedge clk);
      level[0] <= 1'b0;
      repeat (4) @(posedge clk);
    end
    xfer(1'b0, 12'h08c, '0);
    chk({16'h0000, rdat[15:0] - ts}, 32'h0000_0003);
    wrap_up();
  end
endmodule : tb
`default_nettype wire
